// *** rtl/cmt_top.sv ***
`timescale 1ns/1ns
module cmt_top
(
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic IMAGE_PIPELINE_ON,
	input wire logic YUV_FORMAT,
	input wire logic TRANSFORM_MODULE_SELECT,
	input wire logic [2:0] ILLUMINANT_PRESET,
	input wire logic [3:0] COEFFICIENT_SELECT,
	input wire logic CTRL_WR,
	input wire logic CTRL_RD,
	input wire logic CTRL_ENABLE_WR,
	input wire logic TRANSFORM_APPLY_ON_IN,
	input wire logic [31:0] COEFFICIENT_VALUE_IN,
	input wire logic SATURATION_ENABLE,
	input wire logic [cmt_pkg::SAT_W-1:0] SATURATION,
	input wire logic WB_WR,
	input wire logic [cmt_pkg::WB_W-1:0] RED_WB_IN,
	input wire logic [cmt_pkg::WB_W-1:0] BLUE_WB_IN,
	input wire logic [cmt_pkg::PIX_W-1:0] GAMMA_LUT_DATA,
	input wire logic PIX_VALID,
	input wire logic [cmt_pkg::PIX_W-1:0] PIX_R,
	input wire logic [cmt_pkg::PIX_W-1:0] PIX_G,
	input wire logic [cmt_pkg::PIX_W-1:0] PIX_B,
	output logic TRANSFORM_APPLY_ON,
	output logic [31:0] COEFFICIENT_VALUE,
	output logic COEFFICIENT_VALID,
	output logic ACCESS_REFUSED,
	output logic [cmt_pkg::WB_W-1:0] RED_WHITE_BALANCE_RATIO,
	output logic [cmt_pkg::WB_W-1:0] BLUE_WHITE_BALANCE_RATIO,
	output logic OUT_VALID,
	output logic [cmt_pkg::PIX_W-1:0] OUT_C0,
	output logic [cmt_pkg::PIX_W-1:0] OUT_C1,
	output logic [cmt_pkg::PIX_W-1:0] OUT_C2,
	output logic [cmt_pkg::PIX_W-1:0] GAMMA_LUT_ADDR
);
	import cmt_pkg::*;

	typedef logic [COEF_W-1:0] cmt_coef_type;

	// calibrated preset tables, custom slot is writable
	function automatic cmt_coef_type preset_coef(input logic [2:0] p,
		input logic [3:0] i);
		logic signed [COEF_W-1:0] d;
		d = $signed({13'h0000, p}) <<< 4;
		if (i == 4'h0 || i == 4'h4 || i == 4'h8)
			preset_coef = (i == 4'h4) ? GAIN_ONE : GAIN_ONE + d;
		else if (i < 4'h9)
			preset_coef = -(d >>> 1);
		else
			preset_coef = 16'h0000;
	endfunction

	function automatic cmt_coef_type yuv_coef(input logic [3:0] i);
		unique case (i)
			4'h0: yuv_coef = 16'h0132;
			4'h1: yuv_coef = 16'h0259;
			4'h2: yuv_coef = 16'h0075;
			4'h3: yuv_coef = 16'hFF53;
			4'h4: yuv_coef = 16'hFEAD;
			4'h5: yuv_coef = 16'h0200;
			4'h6: yuv_coef = 16'h0200;
			4'h7: yuv_coef = 16'hFE53;
			4'h8: yuv_coef = 16'hFFAD;
			4'h9: yuv_coef = 16'h0000;
			4'hA: yuv_coef = 16'h2000;
			4'hB: yuv_coef = 16'h2000;
			default: yuv_coef = 16'h0000;
		endcase
	endfunction

	// float to fixed and back, single precision
	function automatic cmt_coef_type f2q(input logic [31:0] f);
		logic [7:0] e;
		logic [23:0] m;
		logic [31:0] q;
		int sh;
		e = f[30:23];
		m = {1'b1, f[22:0]};
		sh = int'(e) - 127 + COEF_FRAC - 23;
		if (e == 8'h00)
			q = '0;
		else if (sh >= 0)
			q = (sh > 8) ? 32'h0000_7FFF : 32'(m) << sh;
		else
			q = (sh < -24) ? 32'h0000_0000 : 32'(m) >> (-sh);
		if (q > 32'h0000_7FFF)
			q = 32'h0000_7FFF;
		f2q = f[31] ? COEF_W'(-q) : q[COEF_W-1:0];
	endfunction

	function automatic logic [31:0] q2f(input cmt_coef_type q);
		logic [15:0] a;
		logic [31:0] r;
		int msb;
		a = q[COEF_W-1] ? -q : q;
		msb = 0;
		for (int k = 0; k < 16; k++)
			if (a[k])
				msb = k;
		if (a == 16'h0000)
			r = '0;
		else
			r = {q[COEF_W-1], 8'(msb - COEF_FRAC + 127),
				23'((32'(a) << (23 - msb)))};
		q2f = r;
	endfunction

	cmt_coef_type custom_ff [NUM_COEF];
	cmt_coef_type nxt_custom [NUM_COEF];
	logic apply_ff, nxt_apply, tao_ff, nxt_tao;
	logic [2:0] preset_ff;
	logic [WB_W-1:0] red_wb_ff, nxt_red_wb, blue_wb_ff, nxt_blue_wb;
	logic [31:0] cval_ff, nxt_cval;
	logic cvalid_ff, nxt_cvalid, refused_ff, nxt_refused;
	cmt_ctl_type ctl_ff, nxt_ctl;
	logic [1:0] ipe_sync_ff, yuv_sync_ff;
	logic ipe, yuv;
	logic [NUM_COEF*COEF_W-1:0] rgb_coefs, yuv_coefs;

	assign ipe = ipe_sync_ff[1];
	assign yuv = yuv_sync_ff[1];

	always_comb begin
		for (int i = 0; i < NUM_COEF; i++) begin
			rgb_coefs[i*COEF_W +: COEF_W] = (preset_ff == PRE_CUSTOM) ?
				custom_ff[i] : preset_coef(preset_ff, 4'(i));
			yuv_coefs[i*COEF_W +: COEF_W] = yuv_coef(4'(i));
		end
	end

	// control access
	always_comb begin
		nxt_custom = custom_ff;
		nxt_apply = apply_ff;
		nxt_red_wb = red_wb_ff;
		nxt_blue_wb = blue_wb_ff;
		nxt_cval = cval_ff;
		nxt_cvalid = 1'b0;
		nxt_refused = 1'b0;
		nxt_ctl = CTL_IDLE;
		if (ILLUMINANT_PRESET != preset_ff) begin
			nxt_red_wb = WB_ONE + WB_W'({ILLUMINANT_PRESET, 6'h00});
			nxt_blue_wb = WB_ONE - WB_W'({ILLUMINANT_PRESET, 6'h00});
		end
		if (WB_WR) begin
			nxt_red_wb = RED_WB_IN;
			nxt_blue_wb = BLUE_WB_IN;
		end
		unique case (ctl_ff)
			CTL_IDLE: begin
				if ((CTRL_WR || CTRL_RD || CTRL_ENABLE_WR) && !ipe)
					nxt_refused = 1'b1;
				else if (CTRL_ENABLE_WR) begin
					if (TRANSFORM_MODULE_SELECT == SEL_RGB2RGB)
						nxt_apply = TRANSFORM_APPLY_ON_IN;
					else
						nxt_refused = 1'b1;
				end else if (CTRL_WR) begin
					if (TRANSFORM_MODULE_SELECT == SEL_RGB2RGB &&
						preset_ff == PRE_CUSTOM &&
						COEFFICIENT_SELECT < 4'(NUM_COEF))
						nxt_custom[COEFFICIENT_SELECT] =
							f2q(COEFFICIENT_VALUE_IN);
					else
						nxt_refused = 1'b1;
				end else if (CTRL_RD) begin
					nxt_ctl = CTL_RD;
				end
			end
			CTL_RD: begin
				if (COEFFICIENT_SELECT >= 4'(NUM_COEF))
					nxt_cval = '0;
				else if (TRANSFORM_MODULE_SELECT == SEL_RGB2RGB)
					nxt_cval = q2f(rgb_coefs[COEFFICIENT_SELECT*COEF_W
						+: COEF_W]);
				else
					nxt_cval = q2f(yuv_coefs[COEFFICIENT_SELECT*COEF_W
						+: COEF_W]);
				nxt_cvalid = 1'b1;
				nxt_ctl = CTL_DONE;
			end
			CTL_DONE: nxt_ctl = CTL_IDLE;
		endcase
		nxt_tao = (TRANSFORM_MODULE_SELECT == SEL_RGB2YUV) ?
			yuv : nxt_apply;
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			for (int i = 0; i < NUM_COEF; i++)
				custom_ff[i] <= (i == 0 || i == 4 || i == 8) ?
					GAIN_ONE : 16'h0000;
			apply_ff <= 1'b1;
			tao_ff <= 1'b1;
			preset_ff <= PRE_GENERAL;
			red_wb_ff <= WB_ONE;
			blue_wb_ff <= WB_ONE;
			cval_ff <= '0;
			cvalid_ff <= 1'b0;
			refused_ff <= 1'b0;
			ctl_ff <= CTL_IDLE;
			ipe_sync_ff <= '0;
			yuv_sync_ff <= '0;
		end else begin
			custom_ff <= nxt_custom;
			apply_ff <= nxt_apply;
			tao_ff <= nxt_tao;
			preset_ff <= ILLUMINANT_PRESET;
			red_wb_ff <= nxt_red_wb;
			blue_wb_ff <= nxt_blue_wb;
			cval_ff <= nxt_cval;
			cvalid_ff <= nxt_cvalid;
			refused_ff <= nxt_refused;
			ctl_ff <= nxt_ctl;
			ipe_sync_ff <= {ipe_sync_ff[0], IMAGE_PIPELINE_ON};
			yuv_sync_ff <= {yuv_sync_ff[0], YUV_FORMAT};
		end
	end

	// pixel path: correction, identity gamma, saturation, YUV
	logic cc_v;
	logic [PIX_W-1:0] cc_r, cc_g, cc_b;
	logic [PIX_W-1:0] byp_ff [3];
	logic bv1_ff, bv2_ff;
	logic [PIX_W-1:0] p1_ff [3], nxt_p1 [3];
	logic p1v_ff, nxt_p1v;
	logic y_v;
	logic [PIX_W-1:0] y0, y1, y2;
	logic [PIX_W-1:0] o_ff [3], nxt_o [3];
	logic ov_ff, nxt_ov;
	logic [PIX_W-1:0] byp2_ff [3];

	cmt_mat u_rgb (
		.CLK(CLK),
		.RESETN(RESETN),
		.in_valid(PIX_VALID),
		.in_c0(PIX_R),
		.in_c1(PIX_G),
		.in_c2(PIX_B),
		.coefs(rgb_coefs),
		.out_valid(cc_v),
		.out_c0(cc_r),
		.out_c1(cc_g),
		.out_c2(cc_b)
	);

	function automatic logic [PIX_W-1:0] sat(input logic [PIX_W-1:0] c,
		input logic [PIX_W+1:0] l);
		logic signed [PIX_W+SAT_W+3:0] d;
		d = 20'($signed({2'b00, c})) - 20'($signed({2'b00, l / 3}));
		d = (d * 20'($signed({1'b0, SATURATION}))) >>> SAT_FRAC;
		d = d + 20'($signed({2'b00, l / 3}));
		if (d < 0)
			sat = '0;
		else if (d > $signed(20'(8'hFF)))
			sat = '1;
		else
			sat = d[PIX_W-1:0];
	endfunction

	assign GAMMA_LUT_ADDR = '0;

	always_comb begin
		logic [PIX_W-1:0] c [3];
		logic [PIX_W+1:0] lsum;
		c[0] = apply_ff ? cc_r : byp2_ff[0];
		c[1] = apply_ff ? cc_g : byp2_ff[1];
		c[2] = apply_ff ? cc_b : byp2_ff[2];
		lsum = {2'b00, c[0]} + {2'b00, c[1]} + {2'b00, c[2]};
		nxt_p1v = apply_ff ? cc_v : bv2_ff;
		for (int r = 0; r < 3; r++)
			// gamma as identity stage, then saturation
			nxt_p1[r] = SATURATION_ENABLE ? sat(c[r], lsum) : c[r];
		nxt_ov = yuv ? y_v : p1v_ff;
		nxt_o[0] = yuv ? y0 : p1_ff[0];
		nxt_o[1] = yuv ? y1 : p1_ff[1];
		nxt_o[2] = yuv ? y2 : p1_ff[2];
	end

	cmt_mat u_yuv (
		.CLK(CLK),
		.RESETN(RESETN),
		.in_valid(p1v_ff),
		.in_c0(p1_ff[0]),
		.in_c1(p1_ff[1]),
		.in_c2(p1_ff[2]),
		.coefs(yuv_coefs),
		.out_valid(y_v),
		.out_c0(y0),
		.out_c1(y1),
		.out_c2(y2)
	);

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			bv1_ff <= 1'b0;
			bv2_ff <= 1'b0;
			p1v_ff <= 1'b0;
			ov_ff <= 1'b0;
			for (int r = 0; r < 3; r++) begin
				byp_ff[r] <= '0;
				p1_ff[r] <= '0;
				o_ff[r] <= '0;
				byp2_ff[r] <= '0;
			end
		end else begin
			bv1_ff <= PIX_VALID;
			bv2_ff <= bv1_ff;
			byp_ff[0] <= PIX_R;
			byp_ff[1] <= PIX_G;
			byp_ff[2] <= PIX_B;
			p1v_ff <= nxt_p1v;
			p1_ff <= nxt_p1;
			byp2_ff <= byp_ff;
			ov_ff <= nxt_ov;
			o_ff <= nxt_o;
		end
	end

	assign TRANSFORM_APPLY_ON = tao_ff;
	assign COEFFICIENT_VALUE = cval_ff;
	assign COEFFICIENT_VALID = cvalid_ff;
	assign ACCESS_REFUSED = refused_ff;
	assign RED_WHITE_BALANCE_RATIO = red_wb_ff;
	assign BLUE_WHITE_BALANCE_RATIO = blue_wb_ff;
	assign OUT_VALID = ov_ff;
	assign OUT_C0 = o_ff[0];
	assign OUT_C1 = o_ff[1];
	assign OUT_C2 = o_ff[2];
endmodule // cmt_top

// *** shared/cmt_pkg.sv ***
package cmt_pkg;
	localparam int PIX_W = 8;
	localparam int COEF_W = 16;
	localparam int COEF_FRAC = 10;
	localparam int NUM_COEF = 12;
	localparam int NUM_PRESET = 8;
	localparam int WB_W = 16;
	localparam int SAT_W = 8;
	localparam int SAT_FRAC = 6;
	localparam int PIPE_LAT = 4;
	localparam logic [COEF_W-1:0] GAIN_ONE = 16'h0400;
	localparam logic [WB_W-1:0] WB_ONE = 16'h0400;
	localparam logic [SAT_W-1:0] SAT_RESET = 8'h40;

	typedef enum logic [0:0] {
		SEL_RGB2RGB = 1'b0,
		SEL_RGB2YUV = 1'b1
	} cmt_inst_type;

	typedef enum logic [2:0] {
		PRE_GENERAL = 3'b000,
		PRE_TUNGSTEN = 3'b001,
		PRE_WARM_FL = 3'b010,
		PRE_COOL_FL = 3'b011,
		PRE_DAYLIGHT = 3'b100,
		PRE_CLOUDY = 3'b101,
		PRE_SHADE = 3'b110,
		PRE_CUSTOM = 3'b111
	} cmt_preset_type;

	typedef enum logic [1:0] {
		CTL_IDLE = 2'b00,
		CTL_RD = 2'b01,
		CTL_DONE = 2'b10
	} cmt_ctl_type;
endpackage

// *** rtl/cmt_mat.sv ***
`timescale 1ns/1ns
// one 3x3 matrix plus offsets, two register stages, clamped outputs
module cmt_mat
(
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic in_valid,
	input wire logic [cmt_pkg::PIX_W-1:0] in_c0,
	input wire logic [cmt_pkg::PIX_W-1:0] in_c1,
	input wire logic [cmt_pkg::PIX_W-1:0] in_c2,
	input wire logic [cmt_pkg::NUM_COEF*cmt_pkg::COEF_W-1:0] coefs,
	output logic out_valid,
	output logic [cmt_pkg::PIX_W-1:0] out_c0,
	output logic [cmt_pkg::PIX_W-1:0] out_c1,
	output logic [cmt_pkg::PIX_W-1:0] out_c2
);
	import cmt_pkg::*;
	localparam int ACC_W = PIX_W + COEF_W + 3;
	logic signed [ACC_W-1:0] acc_ff [3];
	logic signed [ACC_W-1:0] nxt_acc [3];
	logic v1_ff, v2_ff;
	logic [PIX_W-1:0] o_ff [3];
	logic [PIX_W-1:0] nxt_o [3];

	function automatic logic signed [COEF_W-1:0] coef(input int idx);
		coef = $signed(coefs[idx*COEF_W +: COEF_W]);
	endfunction

	// both operands widened first so the product cannot overflow
	function automatic logic signed [ACC_W-1:0] prod(input int idx,
		input logic [PIX_W-1:0] p);
		prod = ACC_W'(coef(idx)) * ACC_W'($signed({1'b0, p}));
	endfunction

	function automatic logic [PIX_W-1:0] clamp(
		input logic signed [ACC_W-1:0] v);
		logic signed [ACC_W-1:0] s;
		s = v >>> COEF_FRAC;
		if (s < 0)
			clamp = '0;
		else if (s > ACC_W'((1 << PIX_W) - 1))
			clamp = '1;
		else
			clamp = s[PIX_W-1:0];
	endfunction

	always_comb begin
		for (int r = 0; r < 3; r++) begin
			nxt_acc[r] = prod(r*3, in_c0) + prod(r*3+1, in_c1)
				+ prod(r*3+2, in_c2) + ACC_W'(coef(9+r));
			nxt_o[r] = clamp(acc_ff[r]);
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			v1_ff <= 1'b0;
			v2_ff <= 1'b0;
			for (int r = 0; r < 3; r++) begin
				acc_ff[r] <= '0;
				o_ff[r] <= '0;
			end
		end else begin
			v1_ff <= in_valid;
			v2_ff <= v1_ff;
			acc_ff <= nxt_acc;
			o_ff <= nxt_o;
		end
	end

	assign out_valid = v2_ff;
	assign out_c0 = o_ff[0];
	assign out_c1 = o_ff[1];
	assign out_c2 = o_ff[2];
endmodule // cmt_mat

// *** verification/cmt_asserts.sv ***
`timescale 1ns/1ns
module cmt_asserts
	import cmt_pkg::*;
(
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic IMAGE_PIPELINE_ON,
	input wire logic YUV_FORMAT,
	input wire logic TRANSFORM_MODULE_SELECT,
	input wire logic [2:0] ILLUMINANT_PRESET,
	input wire logic [3:0] COEFFICIENT_SELECT,
	input wire logic CTRL_WR,
	input wire logic CTRL_RD,
	input wire logic CTRL_ENABLE_WR,
	input wire logic WB_WR,
	input wire logic [WB_W-1:0] RED_WB_IN,
	input wire logic PIX_VALID,
	input wire logic TRANSFORM_APPLY_ON,
	input wire logic [31:0] COEFFICIENT_VALUE,
	input wire logic COEFFICIENT_VALID,
	input wire logic ACCESS_REFUSED,
	input wire logic [WB_W-1:0] RED_WHITE_BALANCE_RATIO,
	input wire logic OUT_VALID
);
	logic [2:0] on_ff, nxt_on;
	logic on_all, off_all;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	// pipeline-on history, covers the design's synchroniser delay
	always_comb nxt_on = {on_ff[1:0], IMAGE_PIPELINE_ON};
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) on_ff <= 3'h0;
		else on_ff <= nxt_on;
	end
	assign on_all = &{on_ff, IMAGE_PIPELINE_ON};
	assign off_all = ~|{on_ff, IMAGE_PIPELINE_ON};
	a_off_refuse: assert property (
		(CTRL_WR || CTRL_ENABLE_WR) && off_all |=> ACCESS_REFUSED)
		else $error("access with pipeline off not refused");
	a_yuv_en_ro: assert property (
		CTRL_ENABLE_WR && on_all && TRANSFORM_MODULE_SELECT |=> ACCESS_REFUSED)
		else $error("enable write on yuv instance not refused");
	a_coef_gate: assert property (
		CTRL_WR && on_all && (TRANSFORM_MODULE_SELECT
		|| ILLUMINANT_PRESET != PRE_CUSTOM || COEFFICIENT_SELECT > 4'hb)
		|=> ACCESS_REFUSED)
		else $error("illegal coefficient write not refused");
	a_read_answer: assert property (
		CTRL_RD && on_all |-> ##2 COEFFICIENT_VALID)
		else $error("read answer missing");
	a_valid_pulse: assert property (
		COEFFICIENT_VALID |=> !COEFFICIENT_VALID)
		else $error("coefficient valid longer than one cycle");
	a_value_holds: assert property (
		!COEFFICIENT_VALID |-> $stable(COEFFICIENT_VALUE))
		else $error("coefficient value changed without valid");
	a_wb_load: assert property (
		WB_WR |=> RED_WHITE_BALANCE_RATIO == $past(RED_WB_IN))
		else $error("red ratio not loaded");
	a_pix_out: assert property (
		PIX_VALID |-> ##[3:9] OUT_VALID)
		else $error("pixel output missing");
	a_yuv_flag: assert property (
		TRANSFORM_MODULE_SELECT && $past(TRANSFORM_MODULE_SELECT)
		&& $past(YUV_FORMAT, 1) == YUV_FORMAT
		&& $past(YUV_FORMAT, 2) == YUV_FORMAT
		&& $past(YUV_FORMAT, 3) == YUV_FORMAT
		|-> TRANSFORM_APPLY_ON == YUV_FORMAT)
		else $error("yuv enable does not follow format");
endmodule // cmt_asserts

bind cmt_top cmt_asserts chk_i (.CLK, .RESETN, .IMAGE_PIPELINE_ON,
	.YUV_FORMAT, .TRANSFORM_MODULE_SELECT, .ILLUMINANT_PRESET,
	.COEFFICIENT_SELECT, .CTRL_WR, .CTRL_RD, .CTRL_ENABLE_WR, .WB_WR,
	.RED_WB_IN, .PIX_VALID, .TRANSFORM_APPLY_ON, .COEFFICIENT_VALUE,
	.COEFFICIENT_VALID, .ACCESS_REFUSED, .RED_WHITE_BALANCE_RATIO,
	.OUT_VALID);

// *** verification/cmt_src.sv ***
`timescale 1ns/1ns
// upstream stage: one pixel per send, data scrambled when idle
module cmt_src
	import cmt_pkg::*;
(
	input wire logic clk,
	input wire logic send,
	input wire logic [3*PIX_W-1:0] rgb,
	output logic valid,
	output logic [PIX_W-1:0] pr,
	output logic [PIX_W-1:0] pg,
	output logic [PIX_W-1:0] pb
);
	logic go;
	initial begin
		valid = 1'b0;
		{pr, pg, pb} = '0;
	end
	always @(posedge clk) begin
		go = send;
		#1;
		valid = go;
		{pr, pg, pb} = go ? rgb : ~{pr, pg, pb};
	end
endmodule // cmt_src

// *** verification/color_matrix_transform_tb_top.sv ***
`timescale 1ns/1ns
module color_matrix_transform_tb_top;
	import cmt_pkg::*;
	logic CLK = 1'b0, RESETN = 1'b0, IMAGE_PIPELINE_ON = 1'b0;
	logic YUV_FORMAT = 1'b0, TRANSFORM_MODULE_SELECT = 1'b0;
	logic [2:0] ILLUMINANT_PRESET = 3'h0;
	logic [3:0] COEFFICIENT_SELECT = 4'h0;
	logic CTRL_WR = 1'b0, CTRL_RD = 1'b0, CTRL_ENABLE_WR = 1'b0;
	logic TRANSFORM_APPLY_ON_IN = 1'b0, SATURATION_ENABLE = 1'b0;
	logic [31:0] COEFFICIENT_VALUE_IN = 32'h0000_0000;
	logic [SAT_W-1:0] SATURATION = SAT_RESET;
	logic WB_WR = 1'b0, send = 1'b0, rf;
	logic [WB_W-1:0] RED_WB_IN = 16'h0000, BLUE_WB_IN = 16'h0000;
	logic [PIX_W-1:0] GAMMA_LUT_DATA = 8'h00;
	logic [23:0] rgb = 24'h00_0000;
	logic PIX_VALID, TRANSFORM_APPLY_ON, COEFFICIENT_VALID;
	logic ACCESS_REFUSED, OUT_VALID;
	logic [PIX_W-1:0] PIX_R, PIX_G, PIX_B, OUT_C0, OUT_C1, OUT_C2;
	logic [PIX_W-1:0] GAMMA_LUT_ADDR;
	logic [31:0] COEFFICIENT_VALUE, rv;
	logic [WB_W-1:0] RED_WHITE_BALANCE_RATIO, BLUE_WHITE_BALANCE_RATIO;
	int num_errors = 0, cmp_count = 0;
	always #5 CLK = ~CLK;
	cmt_src src (.clk(CLK), .send(send), .rgb(rgb), .valid(PIX_VALID),
		.pr(PIX_R), .pg(PIX_G), .pb(PIX_B));
	cmt_top uut (.CLK, .RESETN, .IMAGE_PIPELINE_ON, .YUV_FORMAT,
		.TRANSFORM_MODULE_SELECT, .ILLUMINANT_PRESET, .COEFFICIENT_SELECT,
		.CTRL_WR, .CTRL_RD, .CTRL_ENABLE_WR, .TRANSFORM_APPLY_ON_IN,
		.COEFFICIENT_VALUE_IN, .SATURATION_ENABLE, .SATURATION, .WB_WR,
		.RED_WB_IN, .BLUE_WB_IN, .GAMMA_LUT_DATA, .PIX_VALID, .PIX_R,
		.PIX_G, .PIX_B, .TRANSFORM_APPLY_ON, .COEFFICIENT_VALUE,
		.COEFFICIENT_VALID, .ACCESS_REFUSED, .RED_WHITE_BALANCE_RATIO,
		.BLUE_WHITE_BALANCE_RATIO, .OUT_VALID, .OUT_C0, .OUT_C1, .OUT_C2,
		.GAMMA_LUT_ADDR);
	task step(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	task end_sim();
		if (num_errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wt(input logic pix);
		for (int i = 0; i < 12; i++) begin
			if ((pix ? OUT_VALID : COEFFICIENT_VALID) === 1'b1) return;
			step(1);
		end
		num_errors++;
		end_sim();
	endtask
	// one control write; en picks the enable write over a coefficient write
	task acc(input logic en, input logic [3:0] idx, input logic [31:0] v);
		COEFFICIENT_SELECT = idx;
		COEFFICIENT_VALUE_IN = v;
		TRANSFORM_APPLY_ON_IN = v[0];
		CTRL_WR = !en;
		CTRL_ENABLE_WR = en;
		step(1);
		rf = ACCESS_REFUSED;
		CTRL_WR = 1'b0;
		CTRL_ENABLE_WR = 1'b0;
		step(1);
		rf = rf | ACCESS_REFUSED;
	endtask
	task rd(input logic [3:0] idx);
		COEFFICIENT_SELECT = idx;
		CTRL_RD = 1'b1;
		step(1);
		CTRL_RD = 1'b0;
		wt(1'b0);
		rv = COEFFICIENT_VALUE;
		step(3);
	endtask
	task px(input logic [23:0] in, input logic [23:0] exp);
		rgb = in;
		send = 1'b1;
		step(1);
		send = 1'b0;
		wt(1'b1);
		chk({8'h00, OUT_C0, OUT_C1, OUT_C2}, {8'h00, exp});
		step(1);
	endtask
	task s_reset();
		chk({31'h0, TRANSFORM_APPLY_ON}, 32'h1);
		chk({16'h0, RED_WHITE_BALANCE_RATIO}, {16'h0, WB_ONE});
		chk({16'h0, BLUE_WHITE_BALANCE_RATIO}, {16'h0, WB_ONE});
		acc(1'b0, 4'h0, 32'h0000_0000);
		chk({31'h0, rf}, 32'h1);
		acc(1'b1, 4'h0, 32'h0000_0000);
		chk({31'h0, rf}, 32'h1);
		IMAGE_PIPELINE_ON = 1'b1;
		step(3);
	endtask
	task s_bypass();
		acc(1'b1, 4'h0, 32'h0000_0000);
		chk({31'h0, rf}, 32'h0);
		chk({31'h0, TRANSFORM_APPLY_ON}, 32'h0);
		SATURATION = 8'h80;
		px(24'h0a_141e, 24'h0a_141e);
		SATURATION_ENABLE = 1'b1;
		px(24'h0a_141e, 24'h00_1428);
		SATURATION_ENABLE = 1'b0;
	endtask
	task s_custom();
		ILLUMINANT_PRESET = PRE_CUSTOM;
		step(2);
		for (int i = 0; i < 12; i++) begin
			acc(1'b0, 4'(i), i == 0 ? 32'h4000_0000 :
				(i == 4 || i == 8) ? 32'h3f80_0000 : 32'h0000_0000);
			chk({31'h0, rf}, 32'h0);
		end
		acc(1'b0, 4'hc, 32'h0000_0000);
		chk({31'h0, rf}, 32'h1);
		acc(1'b1, 4'h0, 32'h0000_0001);
		px(24'hc8_3200, 24'hff_3200);
		rd(4'h0);
		chk(rv, 32'h4000_0000);
		rd(4'h4);
		chk(rv, 32'h3f80_0000);
	endtask
	task s_preset();
		for (int p = 0; p < 7; p++) begin
			ILLUMINANT_PRESET = 3'(p);
			step(2);
			acc(1'b0, 4'h1, 32'h0000_0000);
			chk({31'h0, rf}, 32'h1);
		end
		RED_WB_IN = 16'h0800;
		BLUE_WB_IN = 16'h0c00;
		WB_WR = 1'b1;
		step(1);
		WB_WR = 1'b0;
		chk({RED_WHITE_BALANCE_RATIO, BLUE_WHITE_BALANCE_RATIO},
			32'h0800_0c00);
		ILLUMINANT_PRESET = PRE_CUSTOM;
		step(2);
	endtask
	task s_yuv();
		TRANSFORM_MODULE_SELECT = 1'b1;
		YUV_FORMAT = 1'b1;
		step(4);
		chk({31'h0, TRANSFORM_APPLY_ON}, 32'h1);
		acc(1'b1, 4'h0, 32'h0000_0000);
		chk({31'h0, rf}, 32'h1);
		chk({31'h0, TRANSFORM_APPLY_ON}, 32'h1);
		acc(1'b0, 4'h0, 32'h0000_0000);
		chk({31'h0, rf}, 32'h1);
		rd(4'h0);
		chk(rv, 32'h3e99_0000);
		px(24'h40_4040, 24'h53_0028);
		YUV_FORMAT = 1'b0;
		step(4);
		chk({31'h0, TRANSFORM_APPLY_ON}, 32'h0);
		TRANSFORM_MODULE_SELECT = 1'b0;
		step(1);
		chk({31'h0, TRANSFORM_APPLY_ON}, 32'h1);
	endtask
	initial begin
		step(6);
		RESETN = 1'b1;
		step(3);
		s_reset();
		s_bypass();
		s_custom();
		s_preset();
		s_yuv();
		end_sim();
	end
endmodule // color_matrix_transform_tb_top
